// ===== i2c_bridge_cfg.svh
// constants for the two-wire slave bridge and its master end
`ifndef I2C_BRIDGE_CFG_SVH
`define I2C_BRIDGE_CFG_SVH
`define CMD_WREN        8'h06
`define CMD_WRITE       8'h02
`define CMD_READ        8'h03
`define CMD_RDSR        8'h05
`define SLV_ADDR0       7'h70
`define SLV_ADDR1       7'h71
`define SLV_ADDR2       7'h72
`define PAGE_MASK       16'h001F
`define BUSY_BIT        0
`define PROG_TIME_US    5000
`define SYS_CLK_MHZ     10
`define PROG_CYCLES     (`PROG_TIME_US * `SYS_CLK_MHZ)
`define SCL_HALF_NS     1250
`define SCL_HALF_CYC    ((`SCL_HALF_NS * `SYS_CLK_MHZ) / 1000)
`endif

// ===== i2c_bridge_pkg.sv
// types shared by both ends of the two-wire bridge
`default_nettype none
package i2c_bridge_pkg;
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_WBYT = 3'b010,
    SL_RBYT = 3'b011,
    SL_ACK  = 3'b100,
    SL_MACK = 3'b101,
    SL_SKIP = 3'b110
  } slave_state_t;

  typedef enum logic [3:0] {
    MS_IDLE  = 4'h0,
    MS_START = 4'h1,
    MS_BIT   = 4'h2,
    MS_ACK   = 4'h3,
    MS_STOP  = 4'h4,
    MS_DONE  = 4'h5
  } master_state_t;
endpackage
`default_nettype wire

// ===== i2c_bus_master.sv
// master end: runs one two-wire transfer per request
`timescale 1ns/1ns
`default_nettype none
`include "i2c_bridge_cfg.svh"
module i2c_bus_master #(
  parameter int HALF_CYC = `SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // link
  i2c_link_if.master      bus,
  // request: nbytes bytes, write when rd is low
  input  wire logic       req,
  input  wire logic       rd,
  input  wire logic [6:0] dev_addr,
  input  wire logic [2:0] nbytes,
  input  wire logic [7:0] wdata,
  input  wire logic       wlast_nack,
  // answer
  output logic            busy,
  output logic            wnext,
  output logic            rvalid,
  output logic [7:0]      rdata,
  output logic            nacked
);
  typedef struct packed {
    i2c_bridge_pkg::master_state_t st;
    logic [15:0] div;
    logic        ph;
    logic [3:0]  bit_n;
    logic [8:0]  sh;
    logic [2:0]  left;
    logic        rd;
    logic        first;
    logic        scl;
    logic        sda;
    logic        rvalid;
    logic        wnext;
    logic [7:0]  rdata;
    logic        nacked;
    logic        s1;
    logic        s2;
  } mst_t;
  mst_t q_r, q_nxt;
  logic tick;

  assign tick = (q_r.div == 16'(HALF_CYC - 1));
  assign busy = (q_r.st != i2c_bridge_pkg::MS_IDLE);
  assign rvalid = q_r.rvalid;
  assign wnext = q_r.wnext;
  assign rdata = q_r.rdata;
  assign nacked = q_r.nacked;
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~q_r.scl;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = ~q_r.sda;

  always_comb begin
    q_nxt = q_r;
    q_nxt.rvalid = 1'b0;
    q_nxt.wnext = 1'b0;
    q_nxt.s1 = bus.sda_line;
    q_nxt.s2 = q_r.s1;
    q_nxt.div = tick ? 16'h0000 : q_r.div + 16'h0001;
    case (q_r.st)
      i2c_bridge_pkg::MS_IDLE: begin
        q_nxt.div = 16'h0000;
        if (req) begin
          q_nxt.st = i2c_bridge_pkg::MS_START;
          q_nxt.rd = rd;
          q_nxt.left = nbytes;
          q_nxt.first = 1'b1;
          q_nxt.nacked = 1'b0;
          q_nxt.sh = {dev_addr, rd, 1'b1};
          q_nxt.sda = 1'b0;
        end
      end
      i2c_bridge_pkg::MS_START: if (tick) begin
        q_nxt.scl = 1'b0;
        q_nxt.ph = 1'b0;
        q_nxt.bit_n = 4'h0;
        q_nxt.st = i2c_bridge_pkg::MS_BIT;
      end
      i2c_bridge_pkg::MS_BIT: if (tick) begin
        // msb first on both directions
        if (!q_r.ph) begin
          q_nxt.sda = q_r.sh[8];
          q_nxt.scl = 1'b1;
        end else begin
          q_nxt.scl = 1'b0;
          q_nxt.sh = {q_r.sh[7:0], q_r.s2};
          q_nxt.bit_n = q_r.bit_n + 4'h1;
          if (q_r.bit_n == 4'h8) begin
            q_nxt.st = i2c_bridge_pkg::MS_ACK;
            q_nxt.first = 1'b0;
            if (!q_r.first)
              q_nxt.left = q_r.left - 3'h1;
            if (q_r.rd && !q_r.first) begin
              q_nxt.rdata = q_r.sh[7:0];
              q_nxt.rvalid = 1'b1;
            end else if (q_r.s2)
              q_nxt.nacked = 1'b1;
          end
        end
        q_nxt.ph = ~q_r.ph;
      end
      i2c_bridge_pkg::MS_ACK: begin
        q_nxt.st = i2c_bridge_pkg::MS_STOP;
        if (!q_r.nacked && q_r.left != 3'h0) begin
          q_nxt.st = i2c_bridge_pkg::MS_BIT;
          q_nxt.bit_n = 4'h0;
          q_nxt.ph = 1'b0;
          if (q_r.rd)
            // master acks every wanted byte, nacks the last
            q_nxt.sh = {8'hFF, (q_r.left == 3'h1) ? 1'b1 : 1'b0};
          else begin
            q_nxt.sh = {wdata, 1'b1};
            q_nxt.wnext = 1'b1;
          end
          if (q_r.rd && q_r.left == 3'h1 && wlast_nack)
            q_nxt.sh = {8'hFF, 1'b1};
        end
      end
      i2c_bridge_pkg::MS_STOP: if (tick) begin
        // stop closes every transfer
        if (!q_r.ph) begin
          q_nxt.sda = 1'b0;
        end else if (!q_r.scl) begin
          q_nxt.scl = 1'b1;
        end else begin
          q_nxt.sda = 1'b1;
          q_nxt.st = i2c_bridge_pkg::MS_DONE;
        end
        q_nxt.ph = 1'b1;
      end
      i2c_bridge_pkg::MS_DONE: if (tick)
        q_nxt.st = i2c_bridge_pkg::MS_IDLE;
      default: q_nxt.st = i2c_bridge_pkg::MS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.scl <= 1'b1;
      q_r.sda <= 1'b1;
      q_r.s1 <= 1'b1;
      q_r.s2 <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== i2c_link_if.sv
// two-wire bus between the bridge slave and the master end
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic s_scl_oe;
  wire  scl_line = ~(scl_oe & ~scl_o);
  wire  sda_line = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport slave  (input scl_line, input sda_line,
                  output s_sda_o, output s_sda_oe, output s_scl_oe);
  modport master (input scl_line, input sda_line,
                  output scl_o, output scl_oe,
                  output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// ===== i2c_link_sva.sv
// wire-level checks on the link joining the master end and the slave
`timescale 1ns/1ns
`default_nettype none
module i2c_link_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // resolved lines
  input wire logic scl_line,
  input wire logic sda_line,
  // slave drivers
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic s_scl_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////
  logic       scl_q;
  logic       sda_q;
  logic [3:0] rise_cnt_r;
  logic       first_r;
  logic       start_w;

  // start seen from sampled lines; counter saturates so it never wraps
  assign start_w = scl_line & scl_q & sda_q & ~sda_line;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rise_cnt_r <= 4'h0;
      first_r <= 1'b0;
    end else begin
      scl_q <= scl_line;
      sda_q <= sda_line;
      if (start_w) begin
        rise_cnt_r <= 4'h0;
        first_r <= 1'b1;
      end else begin
        if (scl_line & ~scl_q & (rise_cnt_r != 4'hF))
          rise_cnt_r <= rise_cnt_r + 4'h1;
        if (s_sda_oe)
          first_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence start_seq;
    scl_line && $past(scl_line) && $fell(sda_line);
  endsequence

  sequence stop_seq;
    scl_line && $past(scl_line) && $rose(sda_line);
  endsequence

  no_stretch_a: assert property (s_scl_oe == 1'b0)
    else $error("slave drives the clock line");
  open_drain_a: assert property (s_sda_oe |-> s_sda_o == 1'b0)
    else $error("slave drives data high");
  high_stable_a: assert property (
    scl_line && $past(scl_line) |-> $stable(s_sda_oe))
    else $error("slave changed data while clock high");
  ack_low_a: assert property ($rose(s_sda_oe) |-> !scl_line)
    else $error("slave began driving while clock high");
  ack_hold_a: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("slave bit shorter than a clock phase");
  stop_release_a: assert property (stop_seq |=> !s_sda_oe [*8])
    else $error("slave drives data after stop");
  start_release_a: assert property (start_seq |=> !s_sda_oe [*8])
    else $error("slave drives data after start");
  addr_frame_a: assert property (
    $rose(s_sda_oe) && first_r |-> rise_cnt_r == 4'h8)
    else $error("address acknowledge not on ninth bit");
  clk_rate_a: assert property ($rose(scl_line) |-> scl_line [*8])
    else $error("clock high phase too short");

  start_c: cover property (start_seq);
endmodule
`default_nettype wire

// ===== i2c_slave_register_bridge.sv
// two-wire slave that turns bus transfers into register commands
`timescale 1ns/1ns
`default_nettype none
`include "i2c_bridge_cfg.svh"
module i2c_slave_register_bridge #(
  parameter logic [6:0] CHAN_OFS = 7'h00,
  parameter int         PROG_CYC = `PROG_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // link
  i2c_link_if.slave        bus,
  // address select pins and bank select
  input  wire logic [1:0]  addr_sel,
  input  wire logic        memory_bank_select,
  // internal command side
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_addr,
  output logic [7:0]       cmd_wdata,
  output logic             cmd_mem,
  output logic             cmd_commit,
  output logic             cmd_abort,
  input  wire logic [7:0]  rd_data,
  // status
  output logic             prog_busy
);
  typedef struct packed {
    i2c_bridge_pkg::slave_state_t st;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [6:0]  my_addr;
    logic        strap_done;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        rw;
    logic [1:0]  idx;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic        addr_ok;
    logic        wren;
    logic        wrote;
    logic [7:0]  tx;
    logic        sda_oe;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_addr;
    logic [7:0]  cmd_wdata;
    logic        cmd_mem;
    logic        commit;
    logic        abort;
    logic        fetch;
    logic [22:0] prog_cnt;
  } slv_t;
  slv_t q_r, q_nxt;
  logic scl_rise, scl_fall, start_c, stop_c, scl_h, sda_h;
  logic [15:0] inc_addr;

  // bit 0 of each synchroniser only feeds bit 1; clock only followed
  assign scl_h = q_r.scl_s[1];
  assign sda_h = q_r.sda_s[1];
  assign scl_rise = scl_h & ~q_r.scl_s[2];
  assign scl_fall = ~scl_h & q_r.scl_s[2];
  assign start_c = scl_h & q_r.scl_s[2] & ~sda_h & q_r.sda_s[2];
  assign stop_c = scl_h & q_r.scl_s[2] & sda_h & ~q_r.sda_s[2];
  // memory writes wrap inside the page
  assign inc_addr = (q_r.cmd_mem)
    ? ((q_r.addr & ~`PAGE_MASK) | ((q_r.addr + 16'h0001) & `PAGE_MASK))
    : q_r.addr + 16'h0001;

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = q_r.sda_oe;
  assign bus.s_scl_oe = 1'b0;
  assign cmd_valid = q_r.cmd_valid;
  assign cmd_code = q_r.cmd_code;
  assign cmd_addr = q_r.cmd_addr;
  assign cmd_wdata = q_r.cmd_wdata;
  assign cmd_mem = q_r.cmd_mem;
  assign cmd_commit = q_r.commit;
  assign cmd_abort = q_r.abort;
  assign prog_busy = (q_r.prog_cnt != 23'h000000);

  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_s = {q_r.scl_s[1:0], bus.scl_line};
    q_nxt.sda_s = {q_r.sda_s[1:0], bus.sda_line};
    q_nxt.cmd_valid = 1'b0;
    q_nxt.commit = 1'b0;
    q_nxt.abort = 1'b0;
    // memory answers to cmd_addr, so data is taken one cycle after it moves
    q_nxt.fetch = 1'b0;
    if (q_r.fetch)
      q_nxt.tx = rd_data;
    // page copy keeps prog_busy high for the program time
    if (q_r.prog_cnt != 23'h000000)
      q_nxt.prog_cnt = q_r.prog_cnt - 23'h000001;
    if (!q_r.strap_done) begin
      // pins caught once after reset release
      q_nxt.strap_done = 1'b1;
      case (addr_sel)
        2'h1:    q_nxt.my_addr = `SLV_ADDR1 + CHAN_OFS;
        2'h2:    q_nxt.my_addr = `SLV_ADDR2 + CHAN_OFS;
        default: q_nxt.my_addr = `SLV_ADDR0 + CHAN_OFS;
      endcase
    end
    if (start_c || stop_c) begin
      // repeated start ends a frame exactly as a stop does
      if (q_r.rw == 1'b0 && q_r.idx == 2'h3 && q_r.st != i2c_bridge_pkg::SL_IDLE
          && q_r.cmd == `CMD_WRITE && q_r.cmd_mem) begin
        // the stop's own clock rise counts as one bit
        if (q_r.wrote && q_r.bitc < 4'h2
            && q_r.st == i2c_bridge_pkg::SL_WBYT) begin
          q_nxt.commit = 1'b1;
          q_nxt.prog_cnt = 23'(PROG_CYC);
        end else
          q_nxt.abort = 1'b1;
        q_nxt.wren = 1'b0;
      end
      q_nxt.sda_oe = 1'b0;
      q_nxt.bitc = 4'h0;
      q_nxt.st = start_c ? i2c_bridge_pkg::SL_ADDR : i2c_bridge_pkg::SL_IDLE;
    end else begin
      case (q_r.st)
        i2c_bridge_pkg::SL_IDLE: q_nxt.sda_oe = 1'b0;
        i2c_bridge_pkg::SL_ADDR, i2c_bridge_pkg::SL_WBYT: begin
          if (scl_rise) begin
            q_nxt.sh = {q_r.sh[6:0], sda_h};
            q_nxt.bitc = q_r.bitc + 4'h1;
          end
          if (scl_fall && q_r.bitc == 4'h8) begin
            q_nxt.bitc = 4'h0;
            q_nxt.st = i2c_bridge_pkg::SL_ACK;
            q_nxt.sda_oe = 1'b1;
            if (q_r.st == i2c_bridge_pkg::SL_ADDR) begin
              // 7-bit only, general call ignored
              if (q_r.sh[7:1] != q_r.my_addr) begin
                q_nxt.sda_oe = 1'b0;
                q_nxt.st = i2c_bridge_pkg::SL_SKIP;
              end else begin
                q_nxt.rw = q_r.sh[0];
                q_nxt.wrote = 1'b0;
                if (!q_r.sh[0])
                  q_nxt.idx = 2'h0;
                else if (q_r.cmd == `CMD_READ && q_r.addr_ok) begin
                  // fetch, then advance
                  q_nxt.fetch = 1'b1;
                  q_nxt.addr = q_r.addr + 16'h0001;
                  q_nxt.addr_ok = 1'b0;
                end else if (q_r.cmd == `CMD_RDSR) begin
                  q_nxt.tx = 8'h00;
                  q_nxt.tx[`BUSY_BIT] = prog_busy;
                end
                q_nxt.cmd_valid = q_r.sh[0] && q_r.cmd == `CMD_READ
                                  && q_r.addr_ok;
                q_nxt.cmd_code = q_r.cmd;
                q_nxt.cmd_addr = q_r.addr;
                q_nxt.cmd_mem = memory_bank_select;
              end
            end else begin
              // command byte, then address high, low, then data
              case (q_r.idx)
                2'h0: begin
                  q_nxt.cmd = q_r.sh;
                  q_nxt.addr_ok = 1'b0;
                  if (q_r.sh == `CMD_WREN)
                    q_nxt.wren = 1'b1;
                end
                2'h1: q_nxt.addr[15:8] = q_r.sh;
                2'h2: begin
                  q_nxt.addr[7:0] = q_r.sh;
                  q_nxt.addr_ok = (q_r.cmd == `CMD_READ);
                end
                default: begin
                  // store then increment
                  if (q_r.cmd == `CMD_WRITE
                      && (!memory_bank_select || q_r.wren)) begin
                    q_nxt.cmd_valid = 1'b1;
                    q_nxt.cmd_code = q_r.cmd;
                    q_nxt.cmd_addr = q_r.addr;
                    q_nxt.cmd_wdata = q_r.sh;
                    q_nxt.cmd_mem = memory_bank_select;
                    q_nxt.addr = inc_addr;
                    q_nxt.wrote = 1'b1;
                  end
                end
              endcase
              if (q_r.idx != 2'h3)
                q_nxt.idx = q_r.idx + 2'h1;
            end
          end
        end
        i2c_bridge_pkg::SL_ACK: if (scl_fall) begin
          q_nxt.sda_oe = 1'b0;
          q_nxt.st = i2c_bridge_pkg::SL_WBYT;
          if (q_r.rw) begin
            q_nxt.st = i2c_bridge_pkg::SL_RBYT;
            q_nxt.sda_oe = ~q_r.tx[7];
            q_nxt.sh = q_r.tx;
          end
        end
        i2c_bridge_pkg::SL_RBYT: if (scl_fall) begin
          q_nxt.bitc = q_r.bitc + 4'h1;
          q_nxt.sh = {q_r.sh[6:0], 1'b0};
          q_nxt.sda_oe = ~q_r.sh[6];
          if (q_r.bitc == 4'h7) begin
            q_nxt.sda_oe = 1'b0;
            q_nxt.bitc = 4'h0;
            q_nxt.st = i2c_bridge_pkg::SL_MACK;
          end
        end
        i2c_bridge_pkg::SL_MACK: if (scl_rise) begin
          if (sda_h)
            q_nxt.st = i2c_bridge_pkg::SL_SKIP;
          else begin
            q_nxt.st = i2c_bridge_pkg::SL_ACK;
            // read command: fetch the byte at addr, then advance
            if (q_r.cmd == `CMD_READ && q_r.cmd_valid == 1'b0) begin
              q_nxt.fetch = 1'b1;
              q_nxt.cmd_valid = 1'b1;
              q_nxt.cmd_code = q_r.cmd;
              q_nxt.cmd_addr = q_r.addr;
              q_nxt.addr = q_r.addr + 16'h0001;
            end
          end
        end
        default: q_nxt.sda_oe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.scl_s <= 3'h7;
      q_r.sda_s <= 3'h7;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench: master end and bridge slave joined by the link
`timescale 1ns/1ns
`default_nettype none
`include "i2c_bridge_cfg.svh"
module testbench;
  // short program time keeps the busy window measurable
  localparam int PROG_CYC = 4000;
  localparam logic [6:0] ME = `SLV_ADDR2;
  logic sys_clk, rst, req, rd, wlast_nack, busy, wnext, rvalid, nacked;
  logic [6:0] dev_addr;
  logic [2:0] nbytes;
  logic [7:0] wdata, rdata, cmd_code, cmd_wdata, rd_data;
  logic [1:0] addr_sel;
  logic memory_bank_select, cmd_valid, cmd_mem, cmd_commit, cmd_abort;
  logic prog_busy;
  logic [15:0] cmd_addr, a;
  int n_mismatch, check_count, seed, n_commit, n_abort, t, j, k;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [24:0] evq[$];

  //////////////////////////////////////////////////////////////////////////
  i2c_link_if link ();
  i2c_bus_master u_i2c_bus_master (.sys_clk(sys_clk), .rst(rst),
    .bus(link), .req(req), .rd(rd), .dev_addr(dev_addr), .nbytes(nbytes),
    .wdata(wdata), .wlast_nack(wlast_nack), .busy(busy), .wnext(wnext),
    .rvalid(rvalid), .rdata(rdata), .nacked(nacked));
  i2c_slave_register_bridge #(.PROG_CYC(PROG_CYC))
    u_i2c_slave_register_bridge (.sys_clk(sys_clk), .rst(rst),
    .bus(link), .addr_sel(addr_sel),
    .memory_bank_select(memory_bank_select), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_mem(cmd_mem), .cmd_commit(cmd_commit), .cmd_abort(cmd_abort),
    .rd_data(rd_data), .prog_busy(prog_busy));
  i2c_link_sva u_i2c_link_sva (.sys_clk(sys_clk), .rst(rst),
    .scl_line(link.scl_line), .sda_line(link.sda_line),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe),
    .s_scl_oe(link.s_scl_oe));

  //////////////////////////////////////////////////////////////////////////
  // memory answers at once: the slave samples it in the fetch cycle
  function automatic logic [7:0] mem_byte(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'hA5;
  endfunction
  assign rd_data = mem_byte(cmd_addr);

  always @(negedge sys_clk) begin
    if (cmd_valid === 1'b1 && cmd_code === `CMD_WRITE)
      evq.push_back({cmd_mem, cmd_addr, cmd_wdata});
    if (cmd_commit === 1'b1)
      n_commit++;
    if (cmd_abort === 1'b1)
      n_abort++;
  end

  task automatic chkv(input logic [24:0] got, input logic [24:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one bus transfer; write bytes come from wq, read bytes land in rq
  task automatic xfer(input logic r, input logic [6:0] ad, input int n);
    int i;
    int w;
    i = 0;
    rq = {};
    @(negedge sys_clk);
    rd = r;
    dev_addr = ad;
    nbytes = 3'(n);
    wdata = r ? 8'h00 : wq[0];
    req = 1'b1;
    @(negedge sys_clk);
    req = 1'b0;
    for (w = 0; w < 20000; w++) begin
      if (rvalid === 1'b1)
        rq.push_back(rdata);
      if (wnext === 1'b1 && i + 1 < wq.size()) begin
        i++;
        wdata = wq[i];
      end
      if (busy !== 1'b1)
        break;
      @(negedge sys_clk);
    end
  endtask

  task automatic put_write(input logic [15:0] ad, input int n);
    int m;
    wq = {`CMD_WRITE, ad[15:8], ad[7:0]};
    for (m = 0; m < n; m++)
      wq.push_back(8'($random(seed)));
    evq = {};
  endtask

  task automatic status(input logic exp);
    wq = {`CMD_RDSR};
    xfer(1'b0, ME, 1);
    xfer(1'b1, ME, 1);
    chkv(25'(rq.size()), 25'h1);
    chk1(rq[0][0], exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    give_verdict();
  end

  initial begin
    seed = 93274;
    {rst, req, rd, dev_addr, nbytes, wdata} = {1'b1, 20'h0};
    {wlast_nack, addr_sel, memory_bank_select} = {1'b1, 2'h2, 1'b0};
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    for (t = 0; t < 4; t++) begin
      a = (t == 0) ? 16'h00FF : 16'($random(seed));
      put_write(a, 3);
      xfer(1'b0, ME, 6);
      chk1(nacked, 1'b0);
      chkv(25'(evq.size()), 25'h3);
      for (j = 0; j < 3; j++)
        chkv(evq[j], {1'b0, a + 16'(j), wq[3 + j]});
      wq = {`CMD_READ, a[15:8], a[7:0]};
      xfer(1'b0, ME, 3);
      xfer(1'b1, ME, 2);
      chkv(25'(rq.size()), 25'h2);
      for (j = 0; j < 2; j++)
        chkv(25'(rq[j]), 25'(mem_byte(a + 16'(j))));
    end
    // read set-up split from its read by another write
    wq = {`CMD_READ, 8'h12, 8'h34};
    xfer(1'b0, ME, 3);
    put_write(16'h0040, 1);
    xfer(1'b0, ME, 4);
    xfer(1'b1, ME, 3);
    chkv(25'(rq[1]), 25'(rq[0]));
    chkv(25'(rq[2]), 25'(rq[0]));
    // the other channel's address is left alone
    put_write(16'h0010, 1);
    xfer(1'b0, `SLV_ADDR0, 4);
    chk1(nacked, 1'b1);
    chkv(25'(evq.size()), 25'h0);
    // memory page write crossing the page end
    memory_bank_select = 1'b1;
    n_commit = 0;
    n_abort = 0;
    wq = {`CMD_WREN};
    xfer(1'b0, ME, 1);
    put_write(16'h013E, 3);
    xfer(1'b0, ME, 6);
    for (j = 0; j < 3; j++)
      chkv(evq[j], {1'b1, 16'h0120 | ((16'h1E + 16'(j)) & 16'h1F),
                    wq[3 + j]});
    repeat (4) @(negedge sys_clk);
    chkv(25'(n_commit), 25'h1);
    chk1(prog_busy, 1'b1);
    status(1'b1);
    for (k = 0; k < PROG_CYC + 100 && prog_busy === 1'b1; k++)
      @(negedge sys_clk);
    chk1(prog_busy, 1'b0);
    status(1'b0);
    // no fresh write enable: the write is dropped
    put_write(16'h0140, 1);
    xfer(1'b0, ME, 4);
    repeat (4) @(negedge sys_clk);
    chkv(25'(n_commit), 25'h1);
    chk1(prog_busy, 1'b0);
    chkv(25'(n_abort), 25'h1);
    memory_bank_select = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
